/* File: rtl/rng_health_defs.svh */
`ifndef RNG_HEALTH_DEFS_SVH
`define RNG_HEALTH_DEFS_SVH
// ==========================================================
// Timing and test constants
`define RNG_CLK_HZ          20000000
`define RNG_TF_RUN_DEF      32
`define RNG_PU_BITS_DEF     1024
`define RNG_OT_WIN_DEF      256
`define RNG_OT_LOW_DEF      64
`define RNG_OT_HIGH_DEF     192
`define RNG_ST_CYCLES       16
`define RNG_AUTO_PERIOD_DEF 65536
`endif

/* File: rtl/rng_health_pkg.sv */
package rng_health_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PWRUP = 3'b001,
    ST_RUN = 3'b011,
    ST_FAIL = 3'b010
  } rng_state_type;
endpackage : rng_health_pkg

/* File: rtl/rng_health_gated_output.sv */
`timescale 1ns/1ps
`include "rng_health_defs.svh"
// Notes on behaviour
// - Total-failure check runs from start-up; failure means no output ever.
// - Total failure in operation discards the word holding post-failure bits.
// - Online test screens raw bits at start-up and during operation.
// - Output blocked until power-up online test passes, and after any defect.
// - Online test runs continuously, one verdict per fixed window.
// - Words delivered are 8 or 16 bits wide.
// - Entropy quality is a property of the source, not of this logic.
// - Continuous output test: equal consecutive 16-bit words flag a defect; in byte mode it takes three equal bytes in a row.
// - Requested self-test forces the alarm line and checks it responds.
// - Self-test starts by software request or autonomously on a timer.
// - Manufacturing data written to a configuration page whose lock holds until the next reset.
module rng_health_gated_output
  import rng_health_pkg::*;
#(
  parameter int TF_RUN      = `RNG_TF_RUN_DEF,
  parameter int PU_BITS     = `RNG_PU_BITS_DEF,
  parameter int OT_WIN      = `RNG_OT_WIN_DEF,
  parameter int OT_LOW      = `RNG_OT_LOW_DEF,
  parameter int OT_HIGH     = `RNG_OT_HIGH_DEF,
  parameter int AUTO_PERIOD = `RNG_AUTO_PERIOD_DEF,
  parameter int CFG_DEPTH   = 16
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_sys_rst,
  input  wire logic        i_raw_bit,
  input  wire logic        i_raw_valid,
  input  wire logic        i_word16,
  input  wire logic        i_word_ready,
  input  wire logic        i_selftest_req,
  input  wire logic        i_alarm_in,
  input  wire logic        i_cfg_we,
  input  wire logic [3:0]  i_cfg_addr,
  input  wire logic [15:0] i_cfg_wdata,
  input  wire logic        i_cfg_lock,
  output logic [15:0]      o_word,
  output logic             o_word_valid,
  output logic             o_word_is16,
  output logic             o_fail_sticky,
  output logic             o_pwrup_done,
  output logic             o_alarm_force,
  output logic             o_selftest_busy,
  output logic             o_selftest_pass,
  output logic             o_cfg_locked,
  output logic [15:0]      o_cfg_rdata
);
  // ==========================================================
  // Input synchronisers (raw source is asynchronous)
  logic [1:0] bit_s_r, val_s_r, alm_s_r;
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      bit_s_r <= 2'h0;
      val_s_r <= 2'h0;
      alm_s_r <= 2'h0;
    end else begin
      bit_s_r <= {bit_s_r[0], i_raw_bit};
      val_s_r <= {val_s_r[0], i_raw_valid};
      alm_s_r <= {alm_s_r[0], i_alarm_in};
    end
  end
  logic raw_b, raw_v, raw_vd_r;
  assign raw_b = bit_s_r[1];
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) raw_vd_r <= 1'b0;
    else raw_vd_r <= val_s_r[1];
  end
  assign raw_v = val_s_r[1] & ~raw_vd_r;

  // ==========================================================
  // Total-failure test: a stuck run of TF_RUN equal bits
  logic        last_b_r;
  logic [15:0] run_r;
  logic        tot_fail;
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      last_b_r <= 1'b0;
      run_r    <= 16'h0;
    end else if (raw_v) begin
      last_b_r <= raw_b;
      run_r    <= (raw_b == last_b_r) ? run_r + 16'h1 : 16'h0;
    end
  end
  assign tot_fail = raw_v && (raw_b == last_b_r) && (run_r >= 16'(TF_RUN - 2));

  // ==========================================================
  // Online test: ones count per window, runs always
  logic [15:0] win_cnt_r, ones_r;
  logic        win_end, ot_defect;
  assign win_end = raw_v && (win_cnt_r == 16'(OT_WIN - 1));
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      win_cnt_r <= 16'h0;
      ones_r    <= 16'h0;
    end else if (raw_v) begin
      win_cnt_r <= win_end ? 16'h0 : win_cnt_r + 16'h1;
      ones_r    <= win_end ? 16'h0 : ones_r + {15'h0, raw_b};
    end
  end
  logic [15:0] ones_fin;
  assign ones_fin  = ones_r + {15'h0, raw_b};
  assign ot_defect = win_end && (ones_fin < 16'(OT_LOW) || ones_fin > 16'(OT_HIGH));

  // ==========================================================
  // Word assembly and output test
  logic [15:0] shreg_r, prev_word_r;
  logic [4:0]  nbits_r;
  logic        prev_ok_r, word_full, cont_fail;
  assign word_full = raw_v && (nbits_r == (i_word16 ? 5'd15 : 5'd7));
  logic [15:0] new_word;
  assign new_word  = {shreg_r[14:0], raw_b};
  assign cont_fail = word_full && prev_ok_r && (new_word == prev_word_r);

  rng_state_type state_r;
  logic [15:0]   pu_cnt_r;
  logic          any_fail;
  assign any_fail = tot_fail | ot_defect | cont_fail;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      state_r  <= ST_IDLE;
      pu_cnt_r <= 16'h0;
    end else begin
      case (state_r)
        ST_IDLE:  state_r <= ST_PWRUP;
        ST_PWRUP: begin
          if (any_fail) state_r <= ST_FAIL;
          else if (raw_v) begin
            pu_cnt_r <= pu_cnt_r + 16'h1;
            if (pu_cnt_r == 16'(PU_BITS - 1)) state_r <= ST_RUN;
          end
        end
        ST_RUN:   if (any_fail) state_r <= ST_FAIL;
        default:  state_r <= ST_FAIL;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      shreg_r     <= 16'h0;
      nbits_r     <= 5'h0;
      prev_word_r <= 16'h0;
      prev_ok_r   <= 1'b0;
    end else if (raw_v) begin
      shreg_r <= new_word;
      nbits_r <= word_full ? 5'h0 : nbits_r + 5'h1;
      if (word_full) begin
        prev_word_r <= new_word;
        prev_ok_r   <= 1'b1;
      end
    end
  end

  // Word is dropped if it completes together with a failure, so no
  // post-failure bit can reach the consumer.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_word       <= 16'h0;
      o_word_valid <= 1'b0;
      o_word_is16  <= 1'b0;
    end else begin
      if (state_r != ST_RUN || any_fail) o_word_valid <= 1'b0;
      else if (word_full && (!o_word_valid || i_word_ready)) begin
        o_word       <= i_word16 ? new_word : {8'h0, new_word[7:0]};
        o_word_is16  <= i_word16;
        o_word_valid <= 1'b1;
      end else if (i_word_ready) o_word_valid <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_fail_sticky <= 1'b0;
      o_pwrup_done  <= 1'b0;
    end else begin
      if (any_fail) o_fail_sticky <= 1'b1;
      if (state_r == ST_RUN) o_pwrup_done <= 1'b1;
    end
  end

  // ==========================================================
  // Alarm line self-test
  logic [15:0] st_cnt_r;
  logic [31:0] auto_cnt_r;
  logic        st_start;
  assign st_start = !o_selftest_busy
                    && (i_selftest_req || auto_cnt_r == 32'(AUTO_PERIOD - 1));
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) auto_cnt_r <= 32'h0;
    else auto_cnt_r <= st_start ? 32'h0 : auto_cnt_r + 32'h1;
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_selftest_busy <= 1'b0;
      o_alarm_force   <= 1'b0;
      o_selftest_pass <= 1'b0;
      st_cnt_r        <= 16'h0;
    end else if (st_start) begin
      o_selftest_busy <= 1'b1;
      o_alarm_force   <= 1'b1;
      o_selftest_pass <= 1'b0;
      st_cnt_r        <= 16'h0;
    end else if (o_selftest_busy) begin
      st_cnt_r <= st_cnt_r + 16'h1;
      if (alm_s_r[1]) o_selftest_pass <= 1'b1;
      if (st_cnt_r == 16'(`RNG_ST_CYCLES - 1)) begin
        o_selftest_busy <= 1'b0;
        o_alarm_force   <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Configuration page, write-locked from i_cfg_lock until reset
  logic [15:0] cfg_mem [CFG_DEPTH];
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) o_cfg_locked <= 1'b0;
    else if (i_cfg_lock) o_cfg_locked <= 1'b1;
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_cfg_we && !o_cfg_locked) cfg_mem[i_cfg_addr] <= i_cfg_wdata;
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) o_cfg_rdata <= 16'h0;
    else o_cfg_rdata <= cfg_mem[i_cfg_addr];
  end
endmodule : rng_health_gated_output

/* File: tb/rng_health_sva.sv */
`timescale 1ns/1ps
module rng_health_sva (
  input wire logic        i_clk_sys,
  input wire logic        i_sys_rst,
  input wire logic        i_word_ready,
  input wire logic        i_selftest_req,
  input wire logic        i_cfg_lock,
  input wire logic [15:0] o_word,
  input wire logic        o_word_valid,
  input wire logic        o_word_is16,
  input wire logic        o_fail_sticky,
  input wire logic        o_pwrup_done,
  input wire logic        o_alarm_force,
  input wire logic        o_selftest_busy,
  input wire logic        o_cfg_locked
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  a_word_gate: assert property ($rose(o_word_valid) |-> o_pwrup_done && !o_fail_sticky)
    else $error("word offered before power-up pass or after failure");
  a_word_hold: assert property (o_word_valid && !i_word_ready |=> o_word_valid && $stable(o_word))
    else $error("word changed or dropped while not accepted");
  a_byte_upper: assert property (o_word_valid && !o_word_is16 |-> o_word[15:8] == 8'h00)
    else $error("byte word has nonzero upper half");
  a_fail_sticky: assert property (o_fail_sticky |=> o_fail_sticky)
    else $error("failure flag cleared without reset");
  a_pwrup_sticky: assert property (o_pwrup_done |=> o_pwrup_done)
    else $error("power-up done flag cleared");
  a_lock_holds: assert property (i_cfg_lock || o_cfg_locked |=> o_cfg_locked)
    else $error("page lock not taken or lost");
  a_st_start: assert property (i_selftest_req && !o_selftest_busy |=> o_selftest_busy)
    else $error("self-test request not taken");
  a_st_length: assert property ($rose(o_selftest_busy) |->
    (o_selftest_busy && o_alarm_force) [*8] ##1 (o_selftest_busy && o_alarm_force) [*8]
    ##1 !o_selftest_busy)
    else $error("self-test length or alarm force wrong");
endmodule : rng_health_sva
bind rng_health_gated_output rng_health_sva u_sva (.*);

/* File: tb/rng_consumer_model.sv */
`timescale 1ns/1ps
module rng_consumer_model (
  input  wire logic i_clk_sys,
  input  wire logic i_sys_rst,
  input  wire logic i_word_valid,
  input  wire logic i_alarm_force,
  output logic      o_word_ready,
  output logic      o_alarm_line
);
  logic [1:0] cnt_r;
  always_ff @(posedge i_clk_sys) cnt_r <= i_sys_rst ? 2'h0 : cnt_r + 2'h1;
  // Stalls three cycles in four so words must stand
  assign o_word_ready = i_word_valid && (cnt_r == 2'h3);
  // Healthy sensor: line follows the forced level
  assign o_alarm_line = i_alarm_force;
endmodule : rng_consumer_model

/* File: tb/tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
  logic i_clk_sys, i_sys_rst, i_raw_bit, i_raw_valid, i_word16, i_selftest_req, i_cfg_we;
  logic i_cfg_lock;
  logic [3:0] i_cfg_addr;
  logic [15:0] i_cfg_wdata;
  wire logic i_word_ready, i_alarm_in, o_word_valid, o_word_is16, o_fail_sticky, o_pwrup_done;
  wire logic o_alarm_force, o_selftest_busy, o_selftest_pass, o_cfg_locked;
  wire logic [15:0] o_word, o_cfg_rdata;
  int errors = 0;
  int samples_checked = 0;
  logic [15:0] cap_word;
  logic        cap_is16;
  int          cap_cnt  = 0;
  int          seen_cnt = 0;
  // Short power-up and self-test periods keep the run brief
  rng_health_gated_output #(.PU_BITS(64), .AUTO_PERIOD(200)) dut (.*);
  rng_consumer_model partner (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_word_valid(o_word_valid), .i_alarm_force(o_alarm_force),
    .o_word_ready(i_word_ready), .o_alarm_line(i_alarm_in));
  initial begin
    i_clk_sys = 0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  // Consumer may take a word before the task looks, so catch it on the accepting edge
  always @(posedge i_clk_sys) begin
    if (o_word_valid === 1'b1 && i_word_ready === 1'b1) begin
      cap_word <= o_word;
      cap_is16 <= o_word_is16;
      cap_cnt  <= cap_cnt + 1;
    end
  end
  task automatic results;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic tick(int n);
    repeat (n) @(negedge i_clk_sys);
  endtask : tick
  task automatic do_reset;
    i_sys_rst = 1;
    tick(8);
    i_sys_rst = 0;
    tick(2);
  endtask : do_reset
  // MSB first; strobe high and low two cycles each
  task automatic send(logic [15:0] v, int nb);
    for (int k = nb - 1; k >= 0; k--) begin
      i_raw_bit = v[k];
      i_raw_valid = 1;
      tick(2);
      i_raw_valid = 0;
      tick(2);
    end
  endtask : send
  task automatic get_word(logic [15:0] exp, logic w16);
    int n = 0;
    while (cap_cnt == seen_cnt && n < 40) begin tick(1); n++; end
    if (n == 40) begin errors++; results(); end
    `CHK("word_count", seen_cnt + 1, cap_cnt)
    seen_cnt = cap_cnt;
    `CHK("o_word", exp, cap_word)
    `CHK("o_word_is16", w16, cap_is16)
  endtask : get_word
  task automatic t_pwrup;
    for (int i = 0; i < 8; i++) send(16'h005a ^ 16'(i), 8);
    tick(6);
    `CHK("o_pwrup_done", 1'b1, o_pwrup_done)
    `CHK("o_fail_sticky", 1'b0, o_fail_sticky)
    send(16'h00b4, 8);
    get_word(16'h00b4, 1'b0);
    i_word16 = 1;
    send(16'hc3a5, 16);
    get_word(16'hc3a5, 1'b1);
  endtask : t_pwrup
  task automatic t_selftest;
    int n = 0;
    while (o_selftest_busy !== 1'b0 && n < 40) begin tick(1); n++; end
    if (n >= 40) begin errors++; results(); end
    i_selftest_req = 1;
    tick(1);
    i_selftest_req = 0;
    `CHK("o_selftest_busy", 1'b1, o_selftest_busy)
    while (o_selftest_busy !== 1'b0 && n < 80) begin tick(1); n++; end
    if (n >= 80) begin errors++; results(); end
    `CHK("o_selftest_pass", 1'b1, o_selftest_pass)
  endtask : t_selftest
  task automatic t_cfg;
    i_cfg_addr = 4'h3;
    i_cfg_wdata = 16'h1234;
    i_cfg_we = 1;
    tick(1);
    i_cfg_we = 0;
    i_cfg_lock = 1;
    tick(1);
    i_cfg_lock = 0;
    i_cfg_wdata = 16'hbeef;
    i_cfg_we = 1;
    tick(1);
    i_cfg_we = 0;
    tick(2);
    `CHK("o_cfg_rdata", 16'h1234, o_cfg_rdata)
    `CHK("o_cfg_locked", 1'b1, o_cfg_locked)
  endtask : t_cfg
  task automatic t_fail;
    for (int i = 0; i < 3; i++) send(16'h0000, 16);
    i_word16 = 0;
    send(16'h00e7, 8);
    tick(8);
    `CHK("o_fail_sticky", 1'b1, o_fail_sticky)
    `CHK("o_word_valid", 1'b0, o_word_valid)
    do_reset();
    for (int i = 0; i < 5; i++) send(16'h0000, 16);
    `CHK("o_pwrup_done", 1'b0, o_pwrup_done)
    `CHK("o_fail_sticky", 1'b1, o_fail_sticky)
  endtask : t_fail
  // Sparse ones, short runs, alternating words: only the window balance test can trip
  task automatic t_online;
    do_reset();
    i_word16 = 1;
    for (int i = 0; i < 15; i++) send(i[0] ? 16'h0001 : 16'h0100, 16);
    tick(2);
    `CHK("o_pwrup_done", 1'b1, o_pwrup_done)
    `CHK("o_fail_sticky", 1'b0, o_fail_sticky)
    send(16'h0001, 16);
    tick(2);
    `CHK("o_fail_sticky", 1'b1, o_fail_sticky)
    `CHK("o_word_valid", 1'b0, o_word_valid)
  endtask : t_online
  initial begin
    {i_sys_rst, i_raw_bit, i_raw_valid, i_word16, i_selftest_req, i_cfg_we, i_cfg_lock} = '0;
    i_cfg_addr = 4'h0;
    i_cfg_wdata = 16'h0000;
    do_reset();
    t_pwrup();
    t_selftest();
    t_cfg();
    t_fail();
    t_online();
    results();
  end
endmodule : tb
